// ==== rtl/ivf_pkg.sv ====
// constants shared by the indirect vco register forwarder
package ivf_pkg;

  // clocking
  localparam int SYS_CLK_MHZ     = 25;
  localparam int FSM_CLK_MAX_MHZ = 50;
  // fsm tick divider never runs faster than the system clock
  localparam int FSM_MIN_DIV     = (SYS_CLK_MHZ + FSM_CLK_MAX_MHZ - 1) / FSM_CLK_MAX_MHZ;

  // host serial frame: rw, 7-bit address, 24-bit data, msb first
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [5:0] HDR_BITS   = 6'h08;
  localparam int         DATA_BITS  = 24;
  localparam int         ADDR_BITS  = 7;

  // register offsets
  localparam logic [6:0] ADDR_INT_DIV     = 7'h03;
  localparam logic [6:0] ADDR_FRAC_DIV    = 7'h04;
  localparam logic [6:0] ADDR_INDIRECT    = 7'h05;
  localparam logic [6:0] ADDR_CAL_CFG     = 7'h0A;
  localparam logic [6:0] ADDR_BAND_STATUS = 7'h10;

  // reset values
  localparam logic [15:0] INDIRECT_RESET = 16'h0000;
  localparam logic [23:0] CAL_CFG_RESET  = 24'h000000;
  localparam logic [23:0] DIV_RESET      = 24'h000000;

  // calibration register fields
  localparam int CAL_FSM_DIS_BIT = 11;
  localparam int CAL_RATE_LSB    = 13;
  localparam int CAL_RATE_MSB    = 14;

  // indirect packet fields
  localparam int PKT_BITS    = 16;
  localparam int TGT_LSB     = 0;
  localparam int TGT_MSB     = 2;
  localparam int IDX_LSB     = 3;
  localparam int IDX_MSB     = 6;
  localparam int PAYLOAD_LSB = 7;
  localparam int PAYLOAD_MSB = 15;
  localparam logic [2:0] VCO_TARGET_ID = 3'h0;

  // vco register file
  localparam logic [3:0] VCO_REG_BAND   = 4'h0;
  localparam logic [3:0] VCO_REG_OUTDIV = 4'h2;
  localparam int         OUTDIV_LSB     = 0;
  localparam int         OUTDIV_MSB     = 2;
  localparam logic [2:0] OUTDIV_BYPASS  = 3'h1;
  localparam logic [2:0] OUTDIV_FUND    = 3'h2;

  // band search duration in fsm ticks
  localparam logic [7:0] CAL_SEARCH_TICKS = 8'h40;

  typedef enum logic [2:0] {
    IVF_CAL_IDLE   = 3'b001,
    IVF_CAL_SEARCH = 3'b010,
    IVF_CAL_SEND   = 3'b100
  } ivf_cal_state_t;

endpackage

// ==== rtl/ivf_vco_regfile.sv ====
// vco side register file, sixteen nine-bit words, registered read ports
`timescale 1ns/1ns
module ivf_vco_regfile (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // write port
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_addr,
  input  wire logic [8:0] wr_data,
  // read ports
  input  wire logic [3:0] rd_addr_a,
  output logic      [8:0] rd_data_a,
  input  wire logic [3:0] rd_addr_b,
  output logic      [8:0] rd_data_b
);

  logic [8:0] mem [16];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 9'h000;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data_a <= 9'h000;
      rd_data_b <= 9'h000;
    end else begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule

// ==== rtl/ivf_forwarder.sv ====
// host serial register port, indirect vco packet forwarder and vco side
`timescale 1ns/1ns
module ivf_forwarder (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // host three-wire serial port
  input  wire logic       spi_sen,
  input  wire logic       spi_sck,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  output logic            spi_sdo_oe,
  // band search result from the search logic
  input  wire logic [8:0] search_band,
  // internal serial link, visible for observation
  output logic            link_clk,
  output logic            link_sel,
  output logic            link_data,
  // vco side state
  output logic      [8:0] vco_band,
  output logic      [2:0] vco_out_div,
  output logic            diff_bypass,
  output logic            diff_fundamental,
  output logic            cal_busy
);

  // terminal count of the fsm tick divider for a rate code
  function automatic logic [2:0] tick_limit(input logic [1:0] rate);
    logic [2:0] lim;
    lim = 3'(ivf_pkg::FSM_MIN_DIV - 1);
    case (rate)
      2'h0:    lim = lim | 3'h0;
      2'h1:    lim = lim | 3'h1;
      2'h2:    lim = lim | 3'h3;
      default: lim = lim | 3'h7;
    endcase
    return lim;
  endfunction

  // synchronised host pins
  logic        sen_s1, sen_s2, sen_d;
  logic        sck_s1, sck_s2, sck_d;
  logic        sdi_s1, sdi_s2;
  logic        sck_rise, sen_end;
  logic [5:0]  bit_cnt;
  logic [31:0] rx_frame;
  logic [23:0] tx_word;
  logic        read_active;
  logic [23:0] read_value;
  logic [6:0]  hdr_addr;
  logic        hdr_done;
  logic        wr_stb;
  logic [6:0]  wr_addr;
  logic [23:0] wr_data;

  // pll side registers
  logic [23:0] int_div;
  logic [23:0] frac_div;
  logic [15:0] vco_indirect_write;
  logic [23:0] cal_cfg;
  logic        host_pending;
  logic        cal_trig;

  // fsm tick
  logic [2:0]  tick_cnt;
  logic        fsm_tick;

  // link transmitter and receiver
  logic        tx_busy;
  logic        tx_phase;
  logic [3:0]  tx_cnt;
  logic [15:0] tx_shift;
  logic        take_host, take_cal;
  logic        link_clk_d;
  logic [15:0] rx_shift;
  logic [4:0]  rx_cnt;
  logic        rx_full;
  logic        vco_wr_en;

  // calibration
  ivf_pkg::ivf_cal_state_t cal_state;
  logic [7:0]  search_cnt;

  // vco register two, full word
  logic [8:0]  vco_out_div_word;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sen_s1 <= 1'b0;
      sen_s2 <= 1'b0;
      sen_d  <= 1'b0;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d  <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sen_s1 <= spi_sen;
      sen_s2 <= sen_s1;
      sen_d  <= sen_s2;
      sck_s1 <= spi_sck;
      sck_s2 <= sck_s1;
      sck_d  <= sck_s2;
      sdi_s1 <= spi_sdi;
      sdi_s2 <= sdi_s1;
    end
  end

  assign sck_rise = sck_s2 & ~sck_d & sen_s2;
  assign sen_end  = ~sen_s2 & sen_d;
  assign hdr_done = sck_rise && (bit_cnt == ivf_pkg::HDR_BITS - 6'h01);
  assign hdr_addr = {rx_frame[5:0], sdi_s2};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bit_cnt  <= 6'h00;
      rx_frame <= 32'h00000000;
    end else if (!sen_s2) begin
      bit_cnt <= 6'h00;
    end else if (sck_rise) begin
      rx_frame <= {rx_frame[30:0], sdi_s2};
      if (bit_cnt != 6'h3F) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // a write commits only on a complete frame, at the end of enable
  assign wr_stb  = sen_end && (bit_cnt == ivf_pkg::FRAME_BITS) && !rx_frame[31];
  assign wr_addr = rx_frame[30:24];
  assign wr_data = rx_frame[23:0];

  // vco register two never appears here; band status reads back the upper eight bits of the vco band word
  always_comb begin
    case (hdr_addr)
      ivf_pkg::ADDR_INT_DIV:     read_value = int_div;
      ivf_pkg::ADDR_FRAC_DIV:    read_value = frac_div;
      ivf_pkg::ADDR_INDIRECT:    read_value = {8'h00, vco_indirect_write};
      ivf_pkg::ADDR_CAL_CFG:     read_value = cal_cfg;
      ivf_pkg::ADDR_BAND_STATUS: read_value = {16'h0000, vco_band[8:1]};
      default:                   read_value = 24'h000000;
    endcase
  end

  // read data shifts after the host has sampled each rising edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_word     <= 24'h000000;
      read_active <= 1'b0;
    end else if (!sen_s2) begin
      read_active <= 1'b0;
    end else if (hdr_done) begin
      tx_word     <= read_value;
      read_active <= rx_frame[6];
    end else if (sck_rise && read_active) begin
      tx_word <= {tx_word[22:0], 1'b0};
    end
  end

  assign spi_sdo    = tx_word[ivf_pkg::DATA_BITS-1];
  assign spi_sdo_oe = read_active & sen_s2;

  // pll side writes land at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_div  <= ivf_pkg::DIV_RESET;
      frac_div <= ivf_pkg::DIV_RESET;
      cal_cfg  <= ivf_pkg::CAL_CFG_RESET;
    end else if (wr_stb) begin
      if (wr_addr == ivf_pkg::ADDR_INT_DIV) int_div <= wr_data;
      if (wr_addr == ivf_pkg::ADDR_FRAC_DIV) frac_div <= wr_data;
      if (wr_addr == ivf_pkg::ADDR_CAL_CFG) cal_cfg <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vco_indirect_write <= ivf_pkg::INDIRECT_RESET;
    end else if (wr_stb && wr_addr == ivf_pkg::ADDR_INDIRECT) begin
      vco_indirect_write <= wr_data[ivf_pkg::PKT_BITS-1:0];
    end
  end

  // a newer write during a shift waits; the set wins over the take
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      host_pending <= 1'b0;
    end else if (wr_stb && wr_addr == ivf_pkg::ADDR_INDIRECT) begin
      host_pending <= 1'b1;
    end else if (take_host) begin
      host_pending <= 1'b0;
    end
  end

  assign cal_trig = wr_stb && !cal_cfg[ivf_pkg::CAL_FSM_DIS_BIT] &&
                    (wr_addr == ivf_pkg::ADDR_INT_DIV || wr_addr == ivf_pkg::ADDR_FRAC_DIV);

  // fsm tick, rate from the calibration register
  // restarted at each packet launch so every link bit lasts two full ticks
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_cnt <= 3'h0;
    end else if (take_host || take_cal) begin
      tick_cnt <= 3'h0;
    end else if (fsm_tick) begin
      tick_cnt <= 3'h0;
    end else begin
      tick_cnt <= tick_cnt + 3'h1;
    end
  end

  assign fsm_tick = (tick_cnt >= tick_limit(cal_cfg[ivf_pkg::CAL_RATE_MSB:ivf_pkg::CAL_RATE_LSB]));

  // calibration controller; a divider write restarts it unless the fsm disable bit of the calibration register is set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cal_state  <= ivf_pkg::IVF_CAL_IDLE;
      search_cnt <= 8'h00;
    end else if (cal_trig) begin
      cal_state  <= ivf_pkg::IVF_CAL_SEARCH;
      search_cnt <= 8'h00;
    end else begin
      case (cal_state)
        ivf_pkg::IVF_CAL_IDLE: begin
          search_cnt <= 8'h00;
        end
        ivf_pkg::IVF_CAL_SEARCH: begin
          if (fsm_tick) begin
            if (search_cnt == ivf_pkg::CAL_SEARCH_TICKS - 8'h01) begin
              // nonzero target: the result is dropped, nothing sent
              cal_state <= (vco_indirect_write[ivf_pkg::TGT_MSB:ivf_pkg::TGT_LSB] == ivf_pkg::VCO_TARGET_ID) ?
                           ivf_pkg::IVF_CAL_SEND : ivf_pkg::IVF_CAL_IDLE;
            end
            search_cnt <= search_cnt + 8'h01;
          end
        end
        ivf_pkg::IVF_CAL_SEND: begin
          if (take_cal) begin
            cal_state <= ivf_pkg::IVF_CAL_IDLE;
          end
        end
        default: begin
          cal_state <= ivf_pkg::IVF_CAL_IDLE;
        end
      endcase
    end
  end

  assign cal_busy = (cal_state != ivf_pkg::IVF_CAL_IDLE);

  // host packets go ahead of the calibration result
  assign take_host = !tx_busy && host_pending;
  assign take_cal  = !tx_busy && !host_pending && (cal_state == ivf_pkg::IVF_CAL_SEND) && !cal_trig;

  // two ticks per bit: data set while clock low, sampled at rise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_busy  <= 1'b0;
      tx_phase <= 1'b0;
      tx_cnt   <= 4'h0;
      tx_shift <= 16'h0000;
    end else if (take_host) begin
      tx_busy  <= 1'b1;
      tx_phase <= 1'b0;
      tx_cnt   <= 4'h0;
      tx_shift <= vco_indirect_write;
    end else if (take_cal) begin
      tx_busy  <= 1'b1;
      tx_phase <= 1'b0;
      tx_cnt   <= 4'h0;
      tx_shift <= {search_band, vco_indirect_write[ivf_pkg::IDX_MSB:ivf_pkg::TGT_LSB]};
    end else if (tx_busy && fsm_tick) begin
      tx_phase <= ~tx_phase;
      if (tx_phase) begin
        if (tx_cnt == 4'(ivf_pkg::PKT_BITS - 1)) begin
          tx_busy <= 1'b0;
        end else begin
          tx_cnt   <= tx_cnt + 4'h1;
          tx_shift <= {tx_shift[14:0], 1'b0};
        end
      end
    end
  end

  assign link_clk  = tx_phase;
  assign link_sel  = tx_busy;
  assign link_data = tx_shift[ivf_pkg::PKT_BITS-1];

  // vco side receiver
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      link_clk_d <= 1'b0;
      rx_shift   <= 16'h0000;
      rx_cnt     <= 5'h00;
      rx_full    <= 1'b0;
    end else begin
      link_clk_d <= link_clk;
      rx_full    <= 1'b0;
      if (!link_sel) begin
        rx_cnt <= 5'h00;
      end else if (link_clk && !link_clk_d) begin
        rx_shift <= {rx_shift[14:0], link_data};
        rx_cnt   <= rx_cnt + 5'h01;
        rx_full  <= (rx_cnt == 5'(ivf_pkg::PKT_BITS - 1));
      end
    end
  end

  assign vco_wr_en = rx_full && (rx_shift[ivf_pkg::TGT_MSB:ivf_pkg::TGT_LSB] == ivf_pkg::VCO_TARGET_ID);

  ivf_vco_regfile u_regfile (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .wr_en     (vco_wr_en),
    .wr_addr   (rx_shift[ivf_pkg::IDX_MSB:ivf_pkg::IDX_LSB]),
    .wr_data   (rx_shift[ivf_pkg::PAYLOAD_MSB:ivf_pkg::PAYLOAD_LSB]),
    .rd_addr_a (ivf_pkg::VCO_REG_BAND),
    .rd_data_a (vco_band),
    .rd_addr_b (ivf_pkg::VCO_REG_OUTDIV),
    .rd_data_b (vco_out_div_word)
  );

  assign vco_out_div = vco_out_div_word[ivf_pkg::OUTDIV_MSB:ivf_pkg::OUTDIV_LSB];

  // differential output routing follows the divide ratio
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      diff_bypass      <= 1'b0;
      diff_fundamental <= 1'b0;
    end else begin
      diff_bypass      <= (vco_out_div == ivf_pkg::OUTDIV_BYPASS);
      diff_fundamental <= (vco_out_div == ivf_pkg::OUTDIV_FUND);
    end
  end

endmodule

// ==== bench/ivf_host_model.sv ====
// host controller model driving the three-wire serial port
`timescale 1ns/1ns
module ivf_host_model (
  // clock
  input  wire logic sys_clk,
  // serial port
  output logic      spi_sen,
  output logic      spi_sck,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  initial begin
    spi_sen = 1'b0;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
  end
  // sck phases of five cycles keep clear of the four-cycle minimum
  task automatic xfer(input logic [31:0] w, output logic [23:0] r);
    r = 24'h000000;
    @(posedge sys_clk) spi_sen <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      @(posedge sys_clk) spi_sdi <= w[i];
      repeat (4) @(posedge sys_clk);
      if (i < 24) r[i] = spi_sdo;
      spi_sck <= 1'b1;
      repeat (5) @(posedge sys_clk);
      spi_sck <= 1'b0;
    end
    repeat (5) @(posedge sys_clk);
    spi_sen <= 1'b0;
    // idle data line shows the inverse, never a stale bit
    spi_sdi <= ~w[0];
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// ==== bench/ivf_forwarder_properties.sv ====
// port-level assertions for the forwarder
`timescale 1ns/1ns
module ivf_forwarder_properties (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // host port
  input wire logic       spi_sen,
  input wire logic       spi_sck,
  input wire logic       spi_sdi,
  input wire logic       spi_sdo,
  input wire logic       spi_sdo_oe,
  input wire logic [8:0] search_band,
  // link and vco side
  input wire logic       link_clk,
  input wire logic       link_sel,
  input wire logic       link_data,
  input wire logic [8:0] vco_band,
  input wire logic [2:0] vco_out_div,
  input wire logic       diff_bypass,
  input wire logic       diff_fundamental,
  input wire logic       cal_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] rise_cnt;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !link_sel) begin
      rise_cnt <= 5'h00;
    end else if ($rose(link_clk)) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end
  sequence s_pkt_start;
    $rose(link_sel);
  endsequence
  sequence s_pkt_end;
    $fell(link_sel);
  endsequence
  property p_idle_low;
    !link_sel |-> !link_clk;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("link clock outside packet");
  property p_first_low;
    s_pkt_start |-> !link_clk ##1 link_sel;
  endproperty
  a_first_low: assert property (p_first_low) else $error("packet starts with clock high");
  property p_bits;
    s_pkt_end |-> rise_cnt == 5'h10;
  endproperty
  a_bits: assert property (p_bits) else $error("packet not sixteen bits");
  property p_hold;
    link_sel && link_clk && $past(link_clk) |-> $stable(link_data);
  endproperty
  a_hold: assert property (p_hold) else $error("link data moved while clock high");
  property p_bypass;
    1'b1 |=> diff_bypass == ($past(vco_out_div) == ivf_pkg::OUTDIV_BYPASS);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass flag wrong");
  property p_fund;
    1'b1 |=> diff_fundamental == ($past(vco_out_div) == ivf_pkg::OUTDIV_FUND);
  endproperty
  a_fund: assert property (p_fund) else $error("fundamental flag wrong");
  property p_oe_idle;
    !spi_sen [*6] |-> !spi_sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven outside frame");
  property p_band_src;
    $changed(vco_band) |-> $past(link_clk, 2) || $past(link_clk, 3) || $past(link_clk, 4);
  endproperty
  a_band_src: assert property (p_band_src) else $error("band changed without link");
endmodule

// ==== bench/ivf_forwarder_test.sv ====
// self-checking bench for the forwarder
`timescale 1ns/1ns
module ivf_forwarder_test;
  logic        sys_clk, rst_n, spi_sen, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe, host_sdo;
  logic        link_clk, link_sel, link_data, diff_bypass, diff_fundamental, cal_busy;
  logic        lclk_q, lsel_q;
  logic [8:0]  search_band, vco_band;
  logic [2:0]  vco_out_div;
  logic [15:0] sh, last_pkt;
  logic [23:0] rd_val;
  logic [7:0]  st;
  int          pkt_n, sel_len, last_len, errors, n_compared, cyc, rate, n;
  logic [6:0]  ra [4] = '{7'h05, 7'h0A, 7'h10, 7'h7F};
  logic [15:0] pk [3] = '{16'h0110, 16'h0090, 16'h0111};
  logic [4:0]  ex [3] = '{5'b010_0_1, 5'b001_1_0, 5'b001_1_0};

  // released sdo toggles every cycle
  assign host_sdo = spi_sdo_oe ? spi_sdo : cyc[0];
  ivf_forwarder ivf_forwarder_i (.sys_clk(sys_clk), .rst_n(rst_n), .spi_sen(spi_sen), .spi_sck(spi_sck),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .search_band(search_band),
    .link_clk(link_clk), .link_sel(link_sel), .link_data(link_data), .vco_band(vco_band),
    .vco_out_div(vco_out_div), .diff_bypass(diff_bypass), .diff_fundamental(diff_fundamental),
    .cal_busy(cal_busy));
  ivf_host_model ivf_host_model_i (.sys_clk(sys_clk), .spi_sen(spi_sen), .spi_sck(spi_sck),
    .spi_sdi(spi_sdi), .spi_sdo(host_sdo));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // link monitor and run limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    lclk_q <= link_clk;
    lsel_q <= link_sel;
    if (link_sel) sel_len <= sel_len + 1;
    if (link_sel && link_clk && !lclk_q) sh <= {sh[14:0], link_data};
    if (lsel_q && !link_sel) begin
      last_pkt <= sh;
      last_len <= sel_len;
      sel_len <= 0;
      pkt_n <= pkt_n + 1;
    end
    if (cyc == 30000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    logic [23:0] r;
    ivf_host_model_i.xfer({1'b0, a, d}, r);
  endtask
  task automatic rd(input logic [6:0] a);
    ivf_host_model_i.xfer({1'b1, a, 24'h000000}, rd_val);
  endtask
  task automatic wait_pkt(input int want);
    int k;
    k = 0;
    while (pkt_n < want && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (6) @(posedge sys_clk);
    chk("packet count", want, pkt_n);
  endtask
  task automatic send(input logic [15:0] p);
    int m;
    m = pkt_n + 1;
    wr(ivf_pkg::ADDR_INDIRECT, {8'h00, p});
    wait_pkt(m);
    chk("packet", p, last_pkt);
    chk("packet cycles", 32 << rate, last_len);
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {rst_n, search_band, lclk_q, lsel_q, sh, last_pkt} = '0;
    {pkt_n, sel_len, last_len, errors, n_compared, cyc, rate} = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      rd(ra[i]);
      chk("reset or unmapped read", 24'h000000, rd_val);
    end
    chk("outputs at reset", 24'h000000, {vco_band, vco_out_div, diff_bypass, diff_fundamental});
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      send(pk[i]);
      chk("out div and flags", ex[i], {vco_out_div, diff_bypass, diff_fundamental});
    end
    rd(ivf_pkg::ADDR_INDIRECT);
    chk("indirect readback", 24'h000111, rd_val);
    $display("test vco writes done");
    wr(ivf_pkg::ADDR_CAL_CFG, 24'h006000);
    rate = 3;
    send(16'h0310);
    rd(ivf_pkg::ADDR_CAL_CFG);
    chk("cal cfg readback", 24'h006000, rd_val);
    $display("test link rate done");
    search_band <= 9'h1A5;
    send(16'h0000);
    n = pkt_n + 1;
    wr(ivf_pkg::ADDR_INT_DIV, 24'h000050);
    wr(ivf_pkg::ADDR_INT_DIV, 24'h000051);
    wait_pkt(n);
    chk("cal packet", {9'h1A5, 7'h00}, last_pkt);
    chk("band", 24'h0001A5, vco_band);
    rd(ivf_pkg::ADDR_BAND_STATUS);
    chk("band status", 24'h0000D2, rd_val);
    st = rd_val[7:0];
    send({st[7:6], 1'b1, st[4:0], 8'h00});
    chk("band kept", {st[7:6], 1'b1, st[4:0], 1'b0}, vco_band);
    search_band <= 9'h0C3;
    n = pkt_n + 1;
    wr(ivf_pkg::ADDR_FRAC_DIV, 24'h001234);
    wait_pkt(n);
    chk("band after frac", 24'h0000C3, vco_band);
    $display("test calibration done");
    rate = 0;
    wr(ivf_pkg::ADDR_CAL_CFG, 24'h000800);
    search_band <= 9'h111;
    n = pkt_n;
    wr(ivf_pkg::ADDR_INT_DIV, 24'h000052);
    repeat (int'(ivf_pkg::CAL_SEARCH_TICKS) + 40) @(posedge sys_clk);
    chk("disabled cal", {15'h0000, 9'h0C3}, {cal_busy, pkt_n[2:0] - n[2:0], vco_band});
    wr(ivf_pkg::ADDR_CAL_CFG, 24'h000000);
    send(16'h0001);
    n = pkt_n;
    wr(ivf_pkg::ADDR_INT_DIV, 24'h000053);
    repeat (int'(ivf_pkg::CAL_SEARCH_TICKS) + 40) @(posedge sys_clk);
    chk("nonzero target cal", {15'h0000, 9'h0C3}, {cal_busy, pkt_n[2:0] - n[2:0], vco_band});
    $display("test cal refusal done");
    give_verdict();
  end
endmodule

bind ivf_forwarder ivf_forwarder_properties ivf_forwarder_properties_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .spi_sen(spi_sen), .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
  .search_band(search_band), .link_clk(link_clk), .link_sel(link_sel), .link_data(link_data),
  .vco_band(vco_band), .vco_out_div(vco_out_div), .diff_bypass(diff_bypass),
  .diff_fundamental(diff_fundamental), .cal_busy(cal_busy));
